//--- design/wor_option_top.sv
/*
 * Write-once option register with its chip-wide option outputs,
 * reached over APB, plus stop recovery and stop-opcode screening.
 * Assumes an APB master on pclk, osc_tick as an enable pulse on pclk,
 * and an asynchronous undervoltage trip pin.
 */
`timescale 1ns/10ps
// Functional notes
// - Only first write after reset is kept
// - Reset reloads the default option image
// - Option register lives at index 0x1f
// - Slow crystal bit sets clock and monitor
// - Detector runs in stop with power+stop bits
// - Detector reset passes only when enabled
// - Power bit switches the detector on/off
// - Rate bit picks short or long watchdog timeout
// - Short bit picks 32 or 4096 wake cycles
// - Stop ended by reset always waits long
// - Stop bit allows stop, else illegal opcode
// - Disable bit turns the watchdog off
module wor_option_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wor_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_tick,
	input wire logic stop_mode,
	input wire logic stop_exit_req,
	input wire logic stop_exit_by_reset,
	input wire logic stop_opcode,
	input wire logic uv_trip_pin,
	output logic slow_crystal_select,
	output logic monitor_low_range,
	output logic undervoltage_detector_power,
	output logic undervoltage_active,
	output logic undervoltage_reset_req,
	output logic watchdog_enable,
	output logic [wor_pkg::WDOG_W-1:0] watchdog_timeout,
	output logic stop_execute,
	output logic illegal_opcode,
	output logic wake_busy,
	output logic wake_release,
	output logic option_locked
);
	import wor_pkg::*;

	logic [7:0] opt_reg;
	logic locked_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic uv_meta_reg;
	logic uv_sync_reg;
	logic slow_reg;
	logic mon_low_reg;
	logic uv_pwr_reg;
	logic uv_act_reg;
	logic uv_rst_reg;
	logic wdog_en_reg;
	logic [WDOG_W-1:0] wdog_to_reg;
	logic stop_exec_reg;
	logic illegal_reg;
	logic wake_busy_reg;
	logic wake_rel_reg;
	logic acc;
	logic opt_wr;
	logic wr_ok;

	wor_wake_if wk ();

	// True when an APB address selects the option register
	function automatic logic opt_hit(input logic [ADDR_W-1:0] a);
		return a == OPT_ADDR;
	endfunction : opt_hit

	// Completing APB access and the write that may land
	assign acc = psel & penable & pready_reg;
	assign opt_wr = acc & pwrite & opt_hit(paddr);
	assign wr_ok = opt_wr & ~locked_reg;

	// Option latches: default on reset, one write per reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_reg <= OPT_RESET;
		end else if (wr_ok) begin
			opt_reg <= pwdata[7:0];
		end
	end

	// Lock closes on the first write to the register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked_reg <= 1'b0;
		end else if (opt_wr) begin
			locked_reg <= 1'b1;
		end
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel & penable & ~pready_reg;
		end
	end

	// Read data and error are set up during the wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= RD_ZERO;
			pslverr_reg <= 1'b0;
		end else if (psel & penable & ~pready_reg) begin
			pslverr_reg <= ~opt_hit(paddr);
			if (!pwrite && opt_hit(paddr)) begin
				prdata_reg <= {RD_PAD, opt_reg};
			end else begin
				prdata_reg <= RD_ZERO;
			end
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	// Two-stage synchroniser for the detector trip pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_meta_reg <= 1'b0;
			uv_sync_reg <= 1'b0;
		end else begin
			uv_meta_reg <= uv_trip_pin;
			uv_sync_reg <= uv_meta_reg;
		end
	end

	// Clock generator crystal range and monitor range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_reg <= OPT_RESET[B_SLOW_XTAL];
			mon_low_reg <= OPT_RESET[B_SLOW_XTAL];
		end else begin
			slow_reg <= opt_reg[B_SLOW_XTAL];
			mon_low_reg <= opt_reg[B_SLOW_XTAL];
		end
	end

	// Undervoltage detector power and activity in stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_pwr_reg <= OPT_RESET[B_UV_POWER];
			uv_act_reg <= OPT_RESET[B_UV_POWER];
		end else begin
			uv_pwr_reg <= opt_reg[B_UV_POWER];
			uv_act_reg <= opt_reg[B_UV_POWER] & (~stop_mode | opt_reg[B_UV_IN_STOP]);
		end
	end

	// Detector reset request passes only when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_rst_reg <= 1'b0;
		end else begin
			uv_rst_reg <= uv_sync_reg & opt_reg[B_UV_RST_EN];
		end
	end

	// Watchdog enable and selected timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_en_reg <= ~OPT_RESET[B_WDOG_DIS];
			wdog_to_reg <= WDOG_LONG;
		end else begin
			wdog_en_reg <= ~opt_reg[B_WDOG_DIS];
			wdog_to_reg <= opt_reg[B_WDOG_RATE] ? WDOG_SHORT : WDOG_LONG;
		end
	end

	// Stop opcode runs or traps as illegal
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_exec_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			stop_exec_reg <= stop_opcode & opt_reg[B_STOP_EN];
			illegal_reg <= stop_opcode & ~opt_reg[B_STOP_EN];
		end
	end

	// Stop recovery request; a reset exit forces the long delay
	assign wk.start = stop_exit_req;
	assign wk.use_long = stop_exit_by_reset | ~opt_reg[B_SHORT_WAKE];

	wor_wake_timer u_wake (
		.pclk(pclk),
		.presetn(presetn),
		.osc_tick(osc_tick),
		.w(wk.tmr)
	);

	// Registered recovery status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_busy_reg <= 1'b0;
			wake_rel_reg <= 1'b0;
		end else begin
			wake_busy_reg <= wk.busy;
			wake_rel_reg <= wk.done;
		end
	end

	// Port drive from the flip-flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign slow_crystal_select = slow_reg;
	assign monitor_low_range = mon_low_reg;
	assign undervoltage_detector_power = uv_pwr_reg;
	assign undervoltage_active = uv_act_reg;
	assign undervoltage_reset_req = uv_rst_reg;
	assign watchdog_enable = wdog_en_reg;
	assign watchdog_timeout = wdog_to_reg;
	assign stop_execute = stop_exec_reg;
	assign illegal_opcode = illegal_reg;
	assign wake_busy = wake_busy_reg;
	assign wake_release = wake_rel_reg;
	assign option_locked = locked_reg;

	a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
		locked_reg |=> $stable(opt_reg) && locked_reg)
		else $error("option value changed after lock");

	a_first_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ok |=> opt_reg == $past(pwdata[7:0]) && locked_reg)
		else $error("first write not latched");

	a_reset_image: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> opt_reg == OPT_RESET && !locked_reg)
		else $error("option default not loaded by reset");

	a_read_value: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && opt_hit(paddr)) |-> prdata_reg == {RD_PAD, opt_reg} && !pslverr_reg)
		else $error("read did not return latched options");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !opt_hit(paddr)) |-> pslverr_reg && prdata_reg == RD_ZERO)
		else $error("unmapped access not refused");

	a_crystal_pair: assert property (@(posedge pclk) disable iff (!presetn)
		##1 (slow_reg == $past(opt_reg[B_SLOW_XTAL]) && mon_low_reg == slow_reg))
		else $error("crystal and monitor range disagree with option");

	a_uv_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_mode && !opt_reg[B_UV_IN_STOP]) |=> !uv_act_reg)
		else $error("detector active in stop without stop bit");

	a_uv_power_off: assert property (@(posedge pclk) disable iff (!presetn)
		!opt_reg[B_UV_POWER] |=> !uv_pwr_reg && !uv_act_reg)
		else $error("detector powered while power bit clear");

	a_uv_reset_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(uv_sync_reg && !opt_reg[B_UV_RST_EN]) |=> !uv_rst_reg)
		else $error("blocked detector reset was forwarded");

	a_wdog_rate: assert property (@(posedge pclk) disable iff (!presetn)
		opt_reg[B_WDOG_RATE] |=> wdog_to_reg == WDOG_SHORT)
		else $error("watchdog short timeout not selected");

	a_stop_screen: assert property (@(posedge pclk) disable iff (!presetn)
		stop_opcode |=> (stop_exec_reg ^ illegal_reg) && stop_exec_reg == $past(opt_reg[B_STOP_EN]))
		else $error("stop opcode misrouted");

	a_wdog_disable: assert property (@(posedge pclk) disable iff (!presetn)
		opt_reg[B_WDOG_DIS] |=> !wdog_en_reg)
		else $error("watchdog enabled while disable bit set");

	a_reset_exit_long: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_exit_req && stop_exit_by_reset) |-> wk.use_long)
		else $error("reset exit did not force long recovery");

	// Each output must also follow its option bit in the other direction
	a_wdog_long: assert property (@(posedge pclk) disable iff (!presetn)
		!opt_reg[B_WDOG_RATE] |=> wdog_to_reg == WDOG_LONG)
		else $error("watchdog long timeout not selected");

	a_wdog_enable: assert property (@(posedge pclk) disable iff (!presetn)
		!opt_reg[B_WDOG_DIS] |=> wdog_en_reg)
		else $error("watchdog off while disable bit clear");

	a_uv_power_on: assert property (@(posedge pclk) disable iff (!presetn)
		opt_reg[B_UV_POWER] |=> uv_pwr_reg)
		else $error("detector unpowered while power bit set");

	a_uv_stop_on: assert property (@(posedge pclk) disable iff (!presetn)
		(opt_reg[B_UV_POWER] && stop_mode && opt_reg[B_UV_IN_STOP]) |=> uv_act_reg)
		else $error("detector idle in stop with both bits set");

	a_uv_awake_on: assert property (@(posedge pclk) disable iff (!presetn)
		(opt_reg[B_UV_POWER] && !stop_mode) |=> uv_act_reg)
		else $error("powered detector idle outside stop");

	a_uv_reset_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(uv_sync_reg && opt_reg[B_UV_RST_EN]) |=> uv_rst_reg)
		else $error("enabled detector reset was blocked");

	// Stray and late bus writes leave the latches alone, an option write locks, wake and crystal choices follow their bits
	a_stray_write: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && !opt_hit(paddr)) |=> $stable(opt_reg) && $stable(locked_reg))
		else $error("unmapped write touched the options");

	a_late_write: assert property (@(posedge pclk) disable iff (!presetn)
		(opt_wr && locked_reg) |=> $stable(opt_reg))
		else $error("write after lock changed the options");

	a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
		opt_wr |=> locked_reg)
		else $error("option write did not lock");

	a_short_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_exit_req && !stop_exit_by_reset && opt_reg[B_SHORT_WAKE]) |-> !wk.use_long)
		else $error("short recovery not chosen");

	a_slow_follow: assert property (@(posedge pclk) disable iff (!presetn)
		opt_reg[B_SLOW_XTAL] |=> slow_reg && mon_low_reg)
		else $error("slow crystal range not applied");

	a_fast_follow: assert property (@(posedge pclk) disable iff (!presetn)
		!opt_reg[B_SLOW_XTAL] |=> !slow_reg && !mon_low_reg)
		else $error("fast crystal range not applied");

	// Disabled stop opcode traps; no stop outcome without an opcode
	a_stop_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_opcode && !opt_reg[B_STOP_EN]) |=> illegal_reg && !stop_exec_reg)
		else $error("disabled stop opcode not trapped");

	a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!stop_opcode |=> !stop_exec_reg && !illegal_reg)
		else $error("stop outcome without opcode");
endmodule : wor_option_top

//--- design/wor_pkg.sv
/*
 * Constants and types for the write-once option register block.
 * Assumes a 32-bit APB slave clocked by pclk; no other dependency.
 */
package wor_pkg;
	// Bus geometry and placement of the option register
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OPT_IDX = 8'h1f;
	localparam logic [ADDR_W-1:0] OPT_ADDR = {OPT_IDX[ADDR_W-3:0], 2'b00};
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam logic [23:0] RD_PAD = 24'h00_0000;
	// Field positions inside the option byte
	localparam int B_WDOG_DIS = 0;
	localparam int B_STOP_EN = 1;
	localparam int B_SHORT_WAKE = 2;
	localparam int B_WDOG_RATE = 3;
	localparam int B_UV_POWER = 4;
	localparam int B_UV_RST_EN = 5;
	localparam int B_UV_IN_STOP = 6;
	localparam int B_SLOW_XTAL = 7;
	// Reset image: detector powered, detector reset enabled, rest clear
	localparam logic [7:0] OPT_RESET = 8'h30;
	// Stop recovery delays in oscillator-clock cycles
	localparam int WAKE_W = 13;
	localparam logic [WAKE_W-1:0] WAKE_SHORT_CYC = 13'h0020;
	localparam logic [WAKE_W-1:0] WAKE_LONG_CYC = 13'h1000;
	localparam logic [WAKE_W-1:0] WAKE_CNT_ONE = 13'h0001;
	// Watchdog timeouts: 2^13-2^4 and 2^18-2^4 oscillator cycles
	localparam int WDOG_W = 18;
	localparam logic [WDOG_W-1:0] WDOG_SHORT = 18'h01ff0;
	localparam logic [WDOG_W-1:0] WDOG_LONG = 18'h3fff0;
	// Recovery timer states, Gray coded along idle-run-done
	typedef enum logic [1:0] {
		WK_IDLE = 2'b00,
		WK_RUN = 2'b01,
		WK_DONE = 2'b11
	} wor_wake_state_t;
endpackage : wor_pkg

//--- design/wor_wake_if.sv
/*
 * Handshake between the option block and its stop recovery timer.
 * Assumes both ends sit on pclk.
 */
`timescale 1ns/10ps
interface wor_wake_if;
	logic start;
	logic use_long;
	logic busy;
	logic done;
	modport ctl (output start, output use_long, input busy, input done);
	modport tmr (input start, input use_long, output busy, output done);
endinterface : wor_wake_if

//--- design/wor_wake_timer.sv
/*
 * Stop recovery timer: counts oscillator ticks after stop mode ends.
 * Assumes osc_tick is a one-cycle enable on pclk at the oscillator rate.
 */
`timescale 1ns/10ps
module wor_wake_timer #(
	parameter logic [wor_pkg::WAKE_W-1:0] SHORT_CYC = wor_pkg::WAKE_SHORT_CYC,
	parameter logic [wor_pkg::WAKE_W-1:0] LONG_CYC = wor_pkg::WAKE_LONG_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic osc_tick,
	wor_wake_if.tmr w
);
	import wor_pkg::*;

	wor_wake_state_t state_reg;
	logic [WAKE_W-1:0] cnt_reg;

	// Sequence idle, counting, one-cycle done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= WK_IDLE;
		end else begin
			case (state_reg)
				WK_IDLE: begin
					if (w.start) begin
						state_reg <= WK_RUN;
					end
				end
				WK_RUN: begin
					if (osc_tick && cnt_reg == WAKE_CNT_ONE) begin
						state_reg <= WK_DONE;
					end
				end
				WK_DONE: begin
					state_reg <= WK_IDLE;
				end
				default: begin
					state_reg <= WK_IDLE;
				end
			endcase
		end
	end

	// Load the chosen delay, then count oscillator ticks down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= LONG_CYC;
		end else if (state_reg == WK_IDLE && w.start) begin
			cnt_reg <= w.use_long ? LONG_CYC : SHORT_CYC;
		end else if (state_reg == WK_RUN && osc_tick) begin
			cnt_reg <= WAKE_W'(cnt_reg - WAKE_CNT_ONE);
		end
	end

	// Status back to the option block
	assign w.busy = (state_reg == WK_RUN);
	assign w.done = (state_reg == WK_DONE);

	a_wake_load: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == WK_IDLE && w.start) |=> w.busy &&
		cnt_reg == ($past(w.use_long) ? LONG_CYC : SHORT_CYC))
		else $error("recovery delay not loaded correctly");

	a_wake_done: assert property (@(posedge pclk) disable iff (!presetn)
		(w.busy && osc_tick && cnt_reg == WAKE_CNT_ONE) |=> w.done ##1 !w.done)
		else $error("recovery done not a single pulse after last tick");
endmodule : wor_wake_timer

//--- bench/testbench.sv
/*
 * Self-checking bench for the write-once option register block.
 * Assumes the design package and top module are compiled first.
 */
`timescale 1ns/10ps
module testbench;
	import wor_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic osc_tick, stop_mode, stop_exit_req, stop_exit_by_reset, stop_opcode, uv_trip_pin;
	logic slow_crystal_select, monitor_low_range, undervoltage_detector_power;
	logic undervoltage_active, undervoltage_reset_req, watchdog_enable;
	logic [WDOG_W-1:0] watchdog_timeout;
	logic stop_execute, illegal_opcode, wake_busy, wake_release, option_locked, er;
	int mismatches = 0;
	int comparisons = 0;
	// Device under test
	wor_option_top wor_option_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
		.stop_mode(stop_mode), .stop_exit_req(stop_exit_req),
		.stop_exit_by_reset(stop_exit_by_reset), .stop_opcode(stop_opcode),
		.uv_trip_pin(uv_trip_pin), .slow_crystal_select(slow_crystal_select),
		.monitor_low_range(monitor_low_range),
		.undervoltage_detector_power(undervoltage_detector_power),
		.undervoltage_active(undervoltage_active),
		.undervoltage_reset_req(undervoltage_reset_req), .watchdog_enable(watchdog_enable),
		.watchdog_timeout(watchdog_timeout), .stop_execute(stop_execute),
		.illegal_opcode(illegal_opcode), .wake_busy(wake_busy),
		.wake_release(wake_release), .option_locked(option_locked));
	// 25 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	// Verdict and end of run
	task automatic complete_run;
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		chk(32'(n < 20), 32'h1, "no pready");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
	endtask : apb
	// Reset held for 4 cycles
	task automatic rst;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : rst
	// Stop opcode pulse, result one cycle later
	task automatic opc(input logic ex);
		stop_opcode <= 1'b1;
		@(posedge pclk);
		stop_opcode <= 1'b0;
		@(negedge pclk);
		chk(32'(stop_execute), 32'(ex), "stop execute");
		chk(32'(illegal_opcode), 32'(!ex), "illegal opcode");
		@(posedge pclk);
	endtask : opc
	// Stop exit and recovery length in ticks
	task automatic wake(input logic byr, input int nexp);
		int n;
		n = 0;
		stop_exit_by_reset <= byr;
		stop_exit_req <= 1'b1;
		@(posedge pclk);
		stop_exit_req <= 1'b0;
		while (wake_release !== 1'b1 && n < 6000) begin
			@(posedge pclk);
			n++;
			if (n == 2) begin
				chk(32'(wake_busy), 32'h1, "recovery busy");
			end
		end
		chk(32'(n == nexp + 2), 32'h1, "recovery length");
		chk(32'(wake_busy), 32'h0, "busy after release");
		@(posedge pclk);
		chk(32'(wake_release), 32'h0, "release one cycle");
	endtask : wake
	// Undervoltage trip through the synchroniser
	task automatic trip(input logic exp);
		uv_trip_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		uv_trip_pin <= 1'b0;
		@(negedge pclk);
		chk(32'(undervoltage_reset_req), 32'(exp), "uv reset request");
		repeat (4) @(posedge pclk);
	endtask : trip
	// Hang guard
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		complete_run();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{stop_mode, stop_exit_req, stop_exit_by_reset, stop_opcode, uv_trip_pin} = '0;
		osc_tick = 1'b1;
		rst();
		apb(1'b0, 8'h7c, 32'h0);
		chk(rd, 32'h30, "reset image");
		chk(32'(er), 32'h0, "err on option read");
		chk(32'(watchdog_timeout), 32'h3fff0, "long timeout");
		chk(32'(watchdog_enable), 32'h1, "watchdog on");
		chk(32'(undervoltage_detector_power), 32'h1, "detector power");
		opc(1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk({rd[31:1], er}, 32'h1, "unmapped read");
		apb(1'b1, 8'h7d, 32'hff);
		chk({31'h0, er}, 32'h1, "unmapped write");
		chk(32'(option_locked), 32'h0, "lock by stray write");
		apb(1'b1, 8'h7c, 32'h8f);
		apb(1'b1, 8'h7c, 32'h70);
		chk(32'(er), 32'h0, "second write error");
		apb(1'b0, 8'h7c, 32'h0);
		chk(rd, 32'h8f, "second write kept out");
		chk(32'(option_locked), 32'h1, "locked");
		chk({30'h0, slow_crystal_select, monitor_low_range}, 32'h3, "slow crystal");
		chk(32'(undervoltage_detector_power), 32'h0, "detector off");
		chk(32'(undervoltage_active), 32'h0, "detector idle");
		chk(32'(watchdog_enable), 32'h0, "watchdog off");
		chk(32'(watchdog_timeout), 32'h01ff0, "short timeout");
		opc(1'b1);
		trip(1'b0);
		wake(1'b0, 32);
		wake(1'b1, 4096);
		rst();
		apb(1'b0, 8'h7c, 32'h0);
		chk({rd[30:0], option_locked}, 32'h60, "defaults again");
		chk({30'h0, slow_crystal_select, monitor_low_range}, 32'h0, "fast crystal");
		apb(1'b1, 8'h7c, 32'h70);
		stop_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(32'(undervoltage_active), 32'h1, "detector in stop");
		@(posedge pclk);
		trip(1'b1);
		stop_mode <= 1'b0;
		wake(1'b0, 4096);
		rst();
		apb(1'b1, 8'h7c, 32'h30);
		stop_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(32'(undervoltage_active), 32'h0, "detector stopped");
		complete_run();
	end
endmodule : testbench
